// ===== logic/ccs_clock_control.sv
// Clock source decode, start-up sequencer and clock-domain gating with APB registers
`timescale 1ns/100ps
`include "ccs_regs.svh"
// How it works
// R1: Core clock off stops all core activity
// R2: Peripheral clock on; async interrupt detect otherwise
// R3: Two-wire address match async while peripherals halted
// R4: Program memory clock follows core clock
// R5: Async timer clock runs in power-save sleep
// R6: Converter keeps own clock in noise reduction
// R7: Four select bits decode the clock source
// R8: Fuse bit one means unprogrammed
// R9: Wake-up counts selected source cycles first
// R10: Reset adds delay counted on watchdog ticks
// R11: Watchdog delay is 4096 or 65536 ticks
// R12: Default config internal RC, longest, divide eight
// R13: Upper crystal select bits pick amplifier mode
// R14: Lowest amplifier mode only for ceramic resonators
// R15: Crystal wake count 258, 1K or 16K
// R16: Crystal reset delay 14 cycles plus watchdog part
// R17: Short crystal wake never with real crystals
// R18: Hold reset, gate core until counts expire
// R19: RC wake 6 cycles; delay by start-up bits
module ccs_clock_control
  import ccs_pkg::*;
#(
  parameter int WDT_LONG  = `CCS_WDT_LONG,
  parameter int WAKE_16K  = `CCS_WAKE_16K,
  parameter int WAKE_32K  = `CCS_WAKE_32K
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_wdt_osc,
  input  wire logic        i_wake,
  output logic             o_internal_reset,
  output logic             o_core_clock_en,
  output logic             o_periph_clock_en,
  output logic             o_flash_clock_en,
  output logic             o_async_clock_en,
  output logic             o_conv_clock_en,
  output logic             o_async_int_detect_en,
  output logic             o_twi_async_addr_en,
  output logic [2:0]       o_osc_source,
  output logic [2:0]       o_osc_amp_mode,
  output logic             o_initial_div8
);
  localparam int CW = 17;  // Counter width, holds 65536

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [6:0]  config_reg, config_next;     // Fuse image, software writable
  logic [6:0]  active_reg, active_next;     // Fuse image in force since last reset
  logic [1:0]  mode_reg, mode_next;         // Sleep mode for the next sleep
  ccs_state_t  state_reg, state_next;       // Sequencer state
  logic        wdt_prev_reg, wdt_prev_next; // Last watchdog oscillator level
  logic [31:0] prdata_reg, prdata_next;     // Read data
  logic        pready_reg, pready_next;     // Access-phase answer
  logic        pslverr_reg, pslverr_next;   // Unmapped address
  logic        wr_en;                       // Write takes effect this edge
  logic        sleep_go;                    // Software asks for sleep
  logic        restart;                     // Software asks for reset sequence
  ccs_source_t src;                         // Decoded source of active image
  logic [CW-1:0] wake_len;                  // Wake count minus one
  logic [CW-1:0] wdt_len;                   // Watchdog delay in ticks
  logic [6:0]  gate_reg, gate_next;         // Domain enables and reset
  logic [2:0]  amp_reg, amp_next;           // Amplifier mode
  logic [2:0]  src_reg;                     // Registered source
  logic        div8_reg;                    // Registered prescale request

  ccs_count_if #(.WIDTH(CW)) count_bus ();

  // ----------------------------------------
  // Fuse decode
  // ----------------------------------------
  // Reserved codes fall back to the 16K wake count and the long watchdog delay, the safe side
  always_comb begin
    logic [3:0] sel;
    logic [1:0] startup_time_select;
    logic [2:0] key;
    sel = active_reg[3:0];
    startup_time_select = active_reg[5:4];
    key = {sel[0], startup_time_select};
    if (sel[3]) begin                                    // R7
      src = CCS_SRC_XTAL;
    end else if (sel[3:2] == 2'b01) begin
      src = CCS_SRC_LFXT;
    end else if (sel == 4'h2) begin
      src = CCS_SRC_RC;
    end else if (sel == 4'h0) begin
      src = CCS_SRC_EXT;
    end else begin
      src = CCS_SRC_RSVD;
    end
    wake_len = CW'(WAKE_16K - 1);
    wdt_len  = CW'(WDT_LONG);
    unique case (src)
      CCS_SRC_XTAL: begin
        if (key <= 3'b001) begin                         // R15
          wake_len = CW'(`CCS_WAKE_258 - 1);
        end else if (key <= 3'b100) begin
          wake_len = CW'(`CCS_WAKE_1K - 1);
        end
        if (key == 3'b010 || key == 3'b101) begin        // R16
          wdt_len = '0;
        end else if (key == 3'b000 || key == 3'b011 || key == 3'b110) begin
          wdt_len = CW'(`CCS_WDT_SHORT);                 // R11
        end
      end
      CCS_SRC_LFXT: begin
        wake_len = sel[0] ? CW'(WAKE_32K - 1) : CW'(`CCS_WAKE_1K - 1);
        wdt_len  = (startup_time_select == 2'b00) ? '0 : (startup_time_select == 2'b01) ? CW'(`CCS_WDT_SHORT) : CW'(WDT_LONG);
      end
      CCS_SRC_RC, CCS_SRC_EXT: begin
        wake_len = CW'(`CCS_WAKE_RC - 1);                // R19
        wdt_len  = (startup_time_select == 2'b00) ? '0 : (startup_time_select == 2'b01) ? CW'(`CCS_WDT_SHORT) : CW'(WDT_LONG);
      end
      CCS_SRC_RSVD: begin
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  assign wr_en    = i_psel & i_penable & pready_reg & i_pwrite;
  assign sleep_go = wr_en & (i_paddr == `CCS_OFS_CONTROL) & i_pwdata[`CCS_CTL_SLEEP_BIT];
  assign restart  = wr_en & (i_paddr == `CCS_OFS_CONTROL) & i_pwdata[`CCS_CTL_RESTART_BIT];

  // Answer one cycle into the access phase, then drop for the next request
  always_comb begin
    config_next  = config_reg;
    mode_next    = mode_reg;
    pready_next  = i_psel & i_penable & ~pready_reg;
    pslverr_next = 1'b0;
    prdata_next  = prdata_reg;
    if (wr_en && i_paddr == `CCS_OFS_CONFIG) begin
      config_next = i_pwdata[6:0];  // Takes effect at the next restart
    end
    if (wr_en && i_paddr == `CCS_OFS_CONTROL) begin
      mode_next = i_pwdata[`CCS_CTL_MODE_LSB +: 2];
    end
    if (pready_next) begin
      prdata_next = 32'h0000_0000;
      unique case (i_paddr)
        `CCS_OFS_CONFIG:  prdata_next[6:0] = config_reg;
        `CCS_OFS_CONTROL: prdata_next[1:0] = mode_reg;
        `CCS_OFS_STATUS:  prdata_next[13:0] = {amp_reg, active_reg, state_reg, 1'b0};
        default:          pslverr_next = 1'b1;  // Unmapped word
      endcase
    end
  end

  // Register bus state
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      config_reg  <= `CCS_CONFIG_RESET;  // R12
      mode_reg    <= 2'b00;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      config_reg  <= config_next;
      mode_reg    <= mode_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  // The counter is loaded on the edge that enters each timed state
  always_comb begin
    state_next         = state_reg;
    active_next        = active_reg;
    wdt_prev_next      = i_wdt_osc;
    count_bus.load     = 1'b0;
    count_bus.length   = '0;
    count_bus.use_tick = (state_reg == CCS_ST_RST_WDT);
    count_bus.tick     = i_wdt_osc & ~wdt_prev_reg;      // R10
    unique case (state_reg)
      CCS_ST_RST_CK: begin
        if (count_bus.done) begin                        // R16
          if (wdt_len == '0) begin
            state_next = CCS_ST_RUN;
          end else begin
            state_next       = CCS_ST_RST_WDT;
            count_bus.load   = 1'b1;
            count_bus.length = wdt_len;                  // R11
          end
        end
      end
      CCS_ST_RST_WDT: begin
        if (count_bus.done) begin                        // R18
          state_next = CCS_ST_RUN;
        end
      end
      CCS_ST_RUN: begin
        if (sleep_go) begin
          state_next = CCS_ST_SLEEP;
        end
      end
      CCS_ST_SLEEP: begin
        if (i_wake) begin
          if (mode_reg[1]) begin                         // R9
            state_next       = CCS_ST_WAKE;
            count_bus.load   = 1'b1;
            count_bus.length = wake_len;
          end else begin
            state_next = CCS_ST_RUN;  // Oscillator kept running, no wait
          end
        end
      end
      CCS_ST_WAKE: begin
        if (count_bus.done) begin                        // R18
          state_next = CCS_ST_RUN;
        end
      end
      default: begin
        state_next = CCS_ST_RST_CK;  // Illegal code restarts safely
      end
    endcase
    if (restart) begin  // Software restart loads the fuse image from config_reg
      state_next       = CCS_ST_RST_CK;
      active_next      = config_reg;
      count_bus.load   = 1'b1;
      count_bus.length = CW'(`CCS_RST_CK_CYCLES - 1);
    end
  end

  // Sequencer state
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg    <= CCS_ST_RST_CK;
      active_reg   <= `CCS_CONFIG_RESET;
      wdt_prev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      active_reg   <= active_next;
      wdt_prev_reg <= wdt_prev_next;
    end
  end

  ccs_startup_counter #(.WIDTH(CW), .RESET_LEN(`CCS_RST_CK_CYCLES - 1)) u_count (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .cnt     (count_bus)
  );

  // ----------------------------------------
  // Clock-domain gating
  // ----------------------------------------
  // Enables follow the next state and next mode so they line up with state_reg and mode_reg
  // gate: {reset, core, periph, flash, async, conv, async detect}
  always_comb begin
    logic run;
    logic slp;
    run       = (state_next == CCS_ST_RUN);
    slp       = (state_next == CCS_ST_SLEEP);
    gate_next = 7'h00;
    gate_next[6] = (state_next == CCS_ST_RST_CK) || (state_next == CCS_ST_RST_WDT); // R18
    gate_next[5] = run;                                                           // R1
    gate_next[4] = run || (slp && mode_next == CCS_SLP_IDLE);                     // R2
    gate_next[3] = run;                                                           // R4
    gate_next[2] = run || (slp && mode_next != CCS_SLP_DOWN);                     // R5
    gate_next[1] = run || (slp && mode_next[1] == 1'b0);                          // R6
    gate_next[0] = !gate_next[4];  // Async detect whenever peripherals halt   R2 R3
    amp_next  = (src == CCS_SRC_XTAL) ? active_reg[3:1] : 3'h0;                   // R13
  end

  // Output flops
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      gate_reg <= 7'h41;
      amp_reg  <= 3'h0;
      src_reg  <= CCS_SRC_RC;
      div8_reg <= 1'b1;
    end else begin
      gate_reg <= gate_next;
      amp_reg  <= amp_next;
      src_reg  <= src;
      div8_reg <= ~active_reg[`CCS_CFG_DIV8_BIT];  // R8
    end
  end

  assign o_prdata              = prdata_reg;
  assign o_pready              = pready_reg;
  assign o_pslverr             = pslverr_reg;
  assign o_internal_reset      = gate_reg[6];
  assign o_core_clock_en       = gate_reg[5];
  assign o_periph_clock_en     = gate_reg[4];
  assign o_flash_clock_en      = gate_reg[3];
  assign o_async_clock_en      = gate_reg[2];
  assign o_conv_clock_en       = gate_reg[1];
  assign o_async_int_detect_en = gate_reg[0];  // R2
  assign o_twi_async_addr_en   = gate_reg[0];  // R3
  assign o_osc_source          = src_reg;
  assign o_osc_amp_mode        = amp_reg;
  assign o_initial_div8        = div8_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // Cycles spent in the reset-clock phase, saturating; a counter keeps the check cheap
  logic [4:0] ck_len_reg, ck_len_next;
  always_comb begin
    ck_len_next = 5'h00;
    if (state_reg == CCS_ST_RST_CK) begin
      ck_len_next = (ck_len_reg == 5'h1F) ? ck_len_reg : ck_len_reg + 5'h01;
    end
  end

  // Phase length register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ck_len_reg <= 5'h00;
    end else begin
      ck_len_reg <= ck_len_next;
    end
  end

  sequence s_rst_ck_exit;
    $fell(state_reg == CCS_ST_RST_CK);
  endsequence
  sequence s_wake_rc;
    (state_reg == CCS_ST_WAKE) [*6];
  endsequence

  a_reset_gates_core: assert property (o_internal_reset |-> !o_core_clock_en) // R18
    else $error("core clock on during internal reset");
  a_core_only_run: assert property (o_core_clock_en |-> state_reg == CCS_ST_RUN) // R1
    else $error("core clock on outside run");
  a_flash_with_core: assert property (o_flash_clock_en == o_core_clock_en) // R4
    else $error("program memory clock differs from core clock");
  a_twi_async_addr: assert property (!o_periph_clock_en |-> o_twi_async_addr_en) // R3
    else $error("no address match while peripherals halted");
  a_async_int_detect: assert property ($fell(o_periph_clock_en) |-> o_async_int_detect_en) // R2
    else $error("async interrupt detect off with peripherals halted");
  a_rst_ck_length: assert property ( // R16
    s_rst_ck_exit |-> ck_len_reg == 5'(`CCS_RST_CK_CYCLES))
    else $error("reset clock phase not 14 cycles");
  a_rc_wake_length: assert property ( // R19
    ($rose(state_reg == CCS_ST_WAKE) && src == CCS_SRC_RC) |-> s_wake_rc ##1 o_core_clock_en)
    else $error("internal RC wake-up not 6 cycles");
  a_save_keeps_async: assert property ( // R5
    (state_reg == CCS_ST_SLEEP && mode_reg == CCS_SLP_SAVE) |-> o_async_clock_en)
    else $error("async timer clock stopped in power-save");
  a_noise_converter: assert property ( // R6
    (state_reg == CCS_ST_SLEEP && mode_reg == CCS_SLP_NOISE) |->
    (o_conv_clock_en && !o_periph_clock_en && !o_core_clock_en))
    else $error("noise reduction gating wrong");
  a_xtal_amp_mode: assert property (src_reg == CCS_SRC_XTAL |-> o_osc_amp_mode >= 3'h4) // R13
    else $error("crystal amplifier mode out of range");
  a_sleep_wake_soon: assert property ( // R9
    (state_reg == CCS_ST_SLEEP && i_wake && !restart && mode_reg[1] == 1'b0) |=> o_core_clock_en)
    else $error("idle wake-up not immediate");
endmodule

// ===== shared/ccs_regs.svh
// Register offsets, field positions, reset values and start-up counts of the clock control block
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CCS_OFS_CONFIG      8'h00
`define CCS_OFS_CONTROL     8'h04
`define CCS_OFS_STATUS      8'h08
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCS_CFG_SEL_LSB     0
`define CCS_CFG_SUT_LSB     4
`define CCS_CFG_DIV8_BIT    6
`define CCS_CTL_MODE_LSB    0
`define CCS_CTL_SLEEP_BIT   2
`define CCS_CTL_RESTART_BIT 3
// ----------------------------------------
// Reset values (fuse 1 = unprogrammed)
// ----------------------------------------
`define CCS_CONFIG_RESET    7'h22
// ----------------------------------------
// Start-up counts
// ----------------------------------------
`define CCS_RST_CK_CYCLES   14
`define CCS_WDT_SHORT       4096
`define CCS_WDT_LONG        65536
`define CCS_WAKE_RC         6
`define CCS_WAKE_258        258
`define CCS_WAKE_1K         1024
`define CCS_WAKE_16K        16384
`define CCS_WAKE_32K        32768
`endif

// ===== shared/ccs_pkg.sv
// Types shared by the clock control block
package ccs_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    CCS_ST_RST_CK  = 3'b000,
    CCS_ST_RST_WDT = 3'b001,
    CCS_ST_RUN     = 3'b010,
    CCS_ST_SLEEP   = 3'b011,
    CCS_ST_WAKE    = 3'b100
  } ccs_state_t;
  // Decoded clock source
  typedef enum logic [2:0] {
    CCS_SRC_EXT   = 3'b000,
    CCS_SRC_RC    = 3'b001,
    CCS_SRC_LFXT  = 3'b010,
    CCS_SRC_XTAL  = 3'b011,
    CCS_SRC_RSVD  = 3'b100
  } ccs_source_t;
  // Sleep modes
  typedef enum logic [1:0] {
    CCS_SLP_IDLE  = 2'b00,
    CCS_SLP_NOISE = 2'b01,
    CCS_SLP_DOWN  = 2'b10,
    CCS_SLP_SAVE  = 2'b11
  } ccs_sleep_t;
endpackage

// ===== shared/ccs_count_if.sv
// Link between the sequencer and its start-up counter
`timescale 1ns/100ps
interface ccs_count_if #(parameter int WIDTH = 17);
  logic             load;      // Load length this cycle
  logic [WIDTH-1:0] length;    // Count to load
  logic             use_tick;  // Count only on watchdog ticks
  logic             tick;      // Watchdog oscillator rising edge
  logic             done;      // Count has reached zero
  modport ctl (output load, output length, output use_tick, output tick, input done);
  modport cnt (input load, input length, input use_tick, input tick, output done);
endinterface

// ===== logic/ccs_startup_counter.sv
// Down counter that times oscillator start-up and reset delays
`timescale 1ns/100ps
`include "ccs_regs.svh"
module ccs_startup_counter #(
  parameter int WIDTH     = 17,
  parameter int RESET_LEN = `CCS_RST_CK_CYCLES - 1
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  ccs_count_if.cnt  cnt
);
  logic [WIDTH-1:0] count_reg;   // Remaining count
  logic [WIDTH-1:0] count_next;

  // ----------------------------------------
  // Next count
  // ----------------------------------------
  // Load wins over decrement so a new phase never inherits a stale count
  always_comb begin
    count_next = count_reg;
    if (cnt.load) begin
      count_next = cnt.length;
    end else if ((count_reg != '0) && (!cnt.use_tick || cnt.tick)) begin
      count_next = count_reg - WIDTH'(1);
    end
  end

  // Register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_reg <= WIDTH'(RESET_LEN);
    end else begin
      count_reg <= count_next;
    end
  end

  assign cnt.done = (count_reg == '0);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_count_loads: assert property (cnt.load |=> count_reg == $past(cnt.length)) // R9
    else $error("counter did not take its load");
  a_wdt_gated: assert property ( // R10
    (!cnt.load && cnt.use_tick && !cnt.tick) |=> count_reg == $past(count_reg))
    else $error("watchdog count moved without a tick");
endmodule

// ===== tb/ccs_wdt_osc_model.sv
// Free-running watchdog oscillator model that feeds the reset delay counter
`timescale 1ns/100ps
module ccs_wdt_osc_model #(
  parameter int HALF = 3  // System cycles per half period of the slow oscillator
) (
  input  wire logic i_clock,
  output logic      o_wdt_osc
);
  // ----------------------------------------
  // Oscillator
  // ----------------------------------------
  int   cnt = 0;     // Half period counter
  logic osc = 1'b0;  // Oscillator level, one driver only
  assign o_wdt_osc = osc;
  // Runs regardless of reset, as the watchdog oscillator never stops
  always @(posedge i_clock) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      osc <= ~osc;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ===== tb/ccs_clock_control_tb.sv
// Self-checking bench for the clock source and start-up control block
`timescale 1ns/100ps
module ccs_clock_control_tb;
  import ccs_pkg::*;
  // ----------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------
  localparam int TICK = 6;  // Watchdog period in system cycles
  logic        i_clock   = 1'b0;
  logic        i_rst     = 1'b1;
  logic        i_psel    = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite  = 1'b0;
  logic [7:0]  i_paddr   = 8'h00;
  logic [31:0] i_pwdata  = 32'h0;
  logic        i_wake    = 1'b0;
  logic        i_wdt_osc;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_internal_reset, o_core_clock_en, o_periph_clock_en;
  logic        o_flash_clock_en, o_async_clock_en, o_conv_clock_en;
  logic        o_async_int_detect_en, o_twi_async_addr_en, o_initial_div8;
  logic [2:0]  o_osc_source, o_osc_amp_mode;
  logic [31:0] rdata;     // Last read data
  logic        last_err;  // Last error response
  int          fails = 0, tests_run = 0, cycles = 0, n;
  wire  [6:0]  en_vec = {o_core_clock_en, o_periph_clock_en, o_flash_clock_en,
                         o_async_clock_en, o_conv_clock_en, o_async_int_detect_en,
                         o_twi_async_addr_en};
  // ----------------------------------------
  // Clock, design and oscillator model
  // ----------------------------------------
  always #5 i_clock = ~i_clock;
  ccs_clock_control #(.WDT_LONG(40), .WAKE_16K(20), .WAKE_32K(24)) ccs_clock_control_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_wdt_osc(i_wdt_osc), .i_wake(i_wake),
    .o_internal_reset(o_internal_reset), .o_core_clock_en(o_core_clock_en),
    .o_periph_clock_en(o_periph_clock_en), .o_flash_clock_en(o_flash_clock_en),
    .o_async_clock_en(o_async_clock_en), .o_conv_clock_en(o_conv_clock_en),
    .o_async_int_detect_en(o_async_int_detect_en),
    .o_twi_async_addr_en(o_twi_async_addr_en), .o_osc_source(o_osc_source),
    .o_osc_amp_mode(o_osc_amp_mode), .o_initial_div8(o_initial_div8));
  ccs_wdt_osc_model #(.HALF(TICK / 2)) ccs_wdt_osc_model_i (
    .i_clock(i_clock), .o_wdt_osc(i_wdt_osc));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard, well above the roughly 1100 cycles the sequence needs
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
  // ----------------------------------------
  // APB master tasks
  // ----------------------------------------
  // Request held from setup until the edge that samples pready high
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= addr;
    i_pwdata <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    // Wait for the edge that samples pready high; only the hang guard ends a stuck wait
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    rdata = o_prdata;
    last_err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic apb_write(input logic [7:0] addr, input logic [31:0] wd);
    apb_xfer(1'b1, addr, wd);
  endtask
  task automatic apb_read(input logic [7:0] addr);
    apb_xfer(1'b0, addr, 32'h0);
  endtask
  // Cycles until internal reset drops, bounded
  task automatic wait_run(output int m);
    m = 0;
    do begin
      @(negedge i_clock);
      m++;
    end while (o_internal_reset !== 1'b0 && m < 2000);
  endtask
  // Load a new fuse image and rerun the reset sequence
  task automatic restart(input logic [6:0] cfg, output int m);
    apb_write(`CCS_OFS_CONFIG, {25'h0, cfg});
    apb_write(`CCS_OFS_CONTROL, 32'h8);
    wait_run(m);
  endtask
  // ----------------------------------------
  // Tables: fuse image, decoded source, amplifier mode
  // ----------------------------------------
  // 7'h68 picks the lowest amplifier mode, a ceramic resonator is assumed
  logic [6:0] cfg_t [8] = '{7'h5F, 7'h6C, 7'h6A, 7'h68, 7'h44, 7'h42, 7'h00, 7'h43};
  logic [2:0] src_t [8] = '{3'b011, 3'b011, 3'b011, 3'b011, 3'b010, 3'b001, 3'b000, 3'b100};
  logic [2:0] amp_t [8] = '{3'b111, 3'b110, 3'b101, 3'b100, 3'b000, 3'b000, 3'b000, 3'b000};
  // Gating per sleep mode {core,periph,flash,async,conv,intdet,twi}
  logic [6:0] slp_t [4] = '{7'b0101100, 7'b0001111, 7'b0000011, 7'b0001011};
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    check(o_internal_reset, 1'b1);
    check(en_vec[6:2], 5'b00000);
    check(o_osc_source, 3'b001);
    check(o_initial_div8, 1'b1);
    @(posedge i_clock);
    i_rst <= 1'b0;
    // Default image: 14 cycles plus the long watchdog delay
    wait_run(n);
    check((n >= 14 + 39 * TICK) && (n <= 16 + 41 * TICK), 1'b1);
    check(en_vec, 7'b1111100);
    apb_read(`CCS_OFS_CONFIG);
    check(rdata, 32'h22);
    apb_read(`CCS_OFS_STATUS);
    check(rdata[3:1], 3'd2);
    apb_read(8'h0C);
    check({last_err, rdata}, {1'b1, 32'h0});
    // Every source class through a restart
    for (int i = 0; i < 8; i++) begin
      restart(cfg_t[i], n);
      check(o_osc_source, src_t[i]);
      check(o_osc_amp_mode, amp_t[i]);
      check(o_initial_div8, !cfg_t[i][6]);
      if (i < 7) check((n >= 14) && (n <= 16), 1'b1);
      else check(n > 14 + 39 * TICK, 1'b1);
    end
    // Reset delay of 14 cycles plus the long watchdog part from a crystal image
    restart(7'h5C, n);
    check((n >= 14 + 39 * TICK) && (n <= 16 + 41 * TICK), 1'b1);
    // Sleep modes with the 16K crystal wake count
    restart(7'h5F, n);
    for (int m = 0; m < 4; m++) begin
      apb_write(`CCS_OFS_CONTROL, 32'h4 | m);
      repeat (3) @(negedge i_clock);
      check(en_vec, slp_t[m]);
      @(posedge i_clock);
      i_wake <= 1'b1;
      n = 0;
      do begin
        @(negedge i_clock);
        n++;
      end while (o_core_clock_en !== 1'b1 && n < 100);
      @(posedge i_clock);
      i_wake <= 1'b0;
      if (m < 2) check(n <= 3, 1'b1);
      else check((n >= 20) && (n <= 23), 1'b1);
      check(en_vec, 7'b1111100);
    end
    // RC wake count of six cycles from power-down
    restart(7'h42, n);
    apb_write(`CCS_OFS_CONTROL, 32'h6);
    @(posedge i_clock);
    i_wake <= 1'b1;
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (o_core_clock_en !== 1'b1 && n < 100);
    @(posedge i_clock);
    i_wake <= 1'b0;
    check((n >= 6) && (n <= 9), 1'b1);
    finish_test();
  end
endmodule
